//--- verilog/wlm_pkg.sv
// wlm_pkg: constants, register map and carrier types for the wake line manager
// assumes an 8-bit register port and one system clock
package wlm_pkg;
    localparam int           LINE_COUNT      = 16;
    localparam logic [2:0]   ADDR_CTRL       = 3'h0;
    localparam logic [2:0]   ADDR_MASK_HIGH  = 3'h1;
    localparam logic [2:0]   ADDR_MASK_LOW   = 3'h2;
    localparam logic [2:0]   ADDR_EDGE_HIGH  = 3'h3;
    localparam logic [2:0]   ADDR_EDGE_LOW   = 3'h4;
    localparam logic [2:0]   ADDR_PEND_HIGH  = 3'h5;
    localparam logic [2:0]   ADDR_PEND_LOW   = 3'h6;
    localparam logic [2:0]   ADDR_STATUS     = 3'h7;
    localparam int           CTRL_WAKE_BIT   = 0;
    localparam int           CTRL_SRC_BIT    = 1;
    localparam int           CTRL_STOP_BIT   = 2;
    localparam int           STAT_EXIT_BIT   = 0;
    localparam logic [7:0]   CTRL_RESET      = 8'h00;
    localparam logic [15:0]  MASK_RESET      = 16'h0000;
    localparam logic [15:0]  EDGE_RESET      = 16'h0000;
    localparam int           CLK_MHZ         = 50;
    localparam int           OSC_RESTART_US  = 100;
    localparam int           OSC_RESTART_CYC = OSC_RESTART_US * CLK_MHZ;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } wlm_bus_s;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ONE, SEQ_ZERO} wlm_seq_e;
    typedef enum logic [1:0] {PM_RUN, PM_STOP, PM_RESTART} wlm_pm_e;
endpackage : wlm_pkg

//--- verilog/wlm_wake_line_manager.sv
// wlm_wake_line_manager: sixteen edge lines feeding the shared irq channel and stop wake-up
// assumes lines are asynchronous pins; cpu acks and irq enable come on sys_clk
`timescale 1ns/1ns
module wlm_wake_line_manager #(
    parameter int OSC_CYC = wlm_pkg::OSC_RESTART_CYC
) (
    input  wire logic                            sys_clk,
    input  wire logic                            rst_b,
    input  wire logic                            clkEn,
    input  wire wlm_pkg::wlm_bus_s               bus,
    output logic [7:0]                           rdData,
    input  wire logic [wlm_pkg::LINE_COUNT-1:0]  extraWakeLine,
    input  wire logic                            dedicatedExtIrqPin,
    input  wire logic                            cpuIrqEnable,
    input  wire logic                            cpuAck,
    output logic                                 sharedExtIrqChannel,
    output logic                                 stopMode,
    output logic                                 clockRun
);
    import wlm_pkg::*;

    logic [LINE_COUNT-1:0] sync1_reg;
    logic [LINE_COUNT-1:0] sync2_reg;
    logic [LINE_COUNT-1:0] prev_reg;
    logic                  pin1_reg;
    logic                  pin2_reg;
    logic [LINE_COUNT-1:0] mask_reg;
    logic [LINE_COUNT-1:0] edge_reg;
    logic [LINE_COUNT-1:0] pend_reg;
    logic [LINE_COUNT-1:0] pend_next;
    logic [LINE_COUNT-1:0] hit;
    logic                  wakeMode_reg;
    logic                  srcSel_reg;
    logic                  stopBit_reg;
    logic                  exitFlag_reg;
    logic                  chan_reg;
    logic                  anyActive;
    logic                  wakeEvent;
    logic                  seqOk;
    logic                  stopWr;
    logic                  otherWr;
    wlm_seq_e              seq_reg;
    wlm_pm_e               pm_reg;
    logic [31:0]           oscCnt_reg;
    logic [1:0]            skip_reg;
    logic                  abortEv;

    assign stopWr  = bus.wr && bus.addr == ADDR_CTRL;
    assign otherWr = bus.wr && bus.addr != ADDR_CTRL;
    assign abortEv = cpuAck || otherWr || wakeEvent;

    // input synchronisers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg  <= '0;
            pin1_reg  <= 1'b0;
            pin2_reg  <= 1'b0;
        end
        else if (clkEn)
        begin
            sync1_reg <= extraWakeLine;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
            pin1_reg  <= dedicatedExtIrqPin;
            pin2_reg  <= pin1_reg;
        end
    end

    // per-line edge detect on selected polarity
    genvar g;
    generate
        for (g = 0; g < LINE_COUNT; g++)
        begin : g_line
            assign hit[g] = edge_reg[g] ? (sync2_reg[g] & ~prev_reg[g])
                                        : (~sync2_reg[g] & prev_reg[g]);
        end
    endgenerate

    // pending: software clear by writing zero, set wins
    always_comb
    begin
        pend_next = pend_reg;
        if (bus.wr && bus.addr == ADDR_PEND_HIGH)
            pend_next[15:8] = pend_reg[15:8] & bus.wdata;
        if (bus.wr && bus.addr == ADDR_PEND_LOW)
            pend_next[7:0] = pend_reg[7:0] & bus.wdata;
        pend_next = pend_next | hit;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            pend_reg <= '0;
        else if (clkEn)
            pend_reg <= pend_next;
    end

    // configuration registers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            mask_reg     <= MASK_RESET;
            edge_reg     <= EDGE_RESET;
            wakeMode_reg <= CTRL_RESET[CTRL_WAKE_BIT];
            srcSel_reg   <= CTRL_RESET[CTRL_SRC_BIT];
        end
        else if (clkEn && bus.wr)
        begin
            case (bus.addr)
                ADDR_CTRL:
                begin
                    wakeMode_reg <= bus.wdata[CTRL_WAKE_BIT];
                    srcSel_reg   <= bus.wdata[CTRL_SRC_BIT];
                end
                ADDR_MASK_HIGH: mask_reg[15:8] <= bus.wdata;
                ADDR_MASK_LOW:  mask_reg[7:0]  <= bus.wdata;
                ADDR_EDGE_HIGH: edge_reg[15:8] <= bus.wdata;
                ADDR_EDGE_LOW:  edge_reg[7:0]  <= bus.wdata;
                default: ;
            endcase
        end
    end

    assign anyActive = |(pend_reg & mask_reg);
    assign wakeEvent = anyActive && wakeMode_reg;
    assign seqOk     = wakeMode_reg && !anyActive && (|mask_reg);

    // shared channel source and rising edge on first unmasked pending
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            chan_reg <= 1'b0;
        else if (clkEn)
            chan_reg <= srcSel_reg ? anyActive : pin2_reg;
    end
    assign sharedExtIrqChannel = chan_reg;

    // stop write sequence
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            seq_reg <= SEQ_IDLE;
        else if (clkEn)
        begin
            if (cpuAck || otherWr || wakeEvent)
                seq_reg <= SEQ_IDLE;
            else if (stopWr && skip_reg == 2'h0)
            begin
                case (seq_reg)
                    SEQ_IDLE: seq_reg <= bus.wdata[CTRL_STOP_BIT] ? SEQ_ONE : SEQ_IDLE;
                    SEQ_ONE:  seq_reg <= bus.wdata[CTRL_STOP_BIT] ? SEQ_ONE : SEQ_ZERO;
                    SEQ_ZERO: seq_reg <= SEQ_IDLE;
                    default:  seq_reg <= SEQ_IDLE;
                endcase
            end
        end
    end

    // writes left over from a broken sequence cannot start a new one
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            skip_reg <= 2'h0;
        else if (clkEn)
        begin
            if (abortEv && seq_reg == SEQ_ONE)
                skip_reg <= 2'h2;
            else if (abortEv && seq_reg == SEQ_ZERO)
                skip_reg <= 2'h1;
            else if (stopWr && skip_reg != 2'h0)
                skip_reg <= skip_reg - 2'h1;
        end
    end

    // power mode, stop bit and exit flag
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            pm_reg       <= PM_RUN;
            stopBit_reg  <= 1'b0;
            exitFlag_reg <= 1'b0;
            oscCnt_reg   <= '0;
        end
        else if (clkEn)
        begin
            case (pm_reg)
                PM_RUN:
                begin
                    if (cpuAck || otherWr || wakeEvent)
                    begin
                        stopBit_reg  <= 1'b0;
                        if (seq_reg != SEQ_IDLE)
                            exitFlag_reg <= 1'b0;
                    end
                    else if (stopWr && skip_reg != 2'h0)
                        stopBit_reg <= 1'b0;
                    else if (stopWr && seq_reg == SEQ_ZERO
                             && bus.wdata[CTRL_STOP_BIT] && seqOk)
                    begin
                        stopBit_reg <= 1'b1;
                        pm_reg      <= PM_STOP;
                    end
                    else if (stopWr)
                    begin
                        stopBit_reg <= bus.wdata[CTRL_STOP_BIT] && seq_reg == SEQ_IDLE;
                        if (bus.wdata[CTRL_STOP_BIT] && seq_reg == SEQ_IDLE)
                            exitFlag_reg <= 1'b0;
                    end
                    else if (bus.wr && bus.addr == ADDR_STATUS
                             && !bus.wdata[STAT_EXIT_BIT])
                        exitFlag_reg <= 1'b0;
                end
                PM_STOP:
                begin
                    if (wakeEvent)
                    begin
                        stopBit_reg  <= 1'b0;
                        exitFlag_reg <= 1'b1;
                        oscCnt_reg   <= '0;
                        pm_reg       <= PM_RESTART;
                    end
                end
                PM_RESTART:
                begin
                    if (oscCnt_reg >= 32'(OSC_CYC - 1))
                        pm_reg <= PM_RUN;
                    else
                        oscCnt_reg <= oscCnt_reg + 32'h1;
                end
                default: pm_reg <= PM_RUN;
            endcase
        end
    end

    assign stopMode = pm_reg != PM_RUN;
    assign clockRun = pm_reg == PM_RUN;

    // register read port
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            rdData <= 8'h00;
        else if (clkEn && bus.rd)
        begin
            case (bus.addr)
                ADDR_CTRL:      rdData <= {5'h00, stopBit_reg, srcSel_reg, wakeMode_reg};
                ADDR_MASK_HIGH: rdData <= mask_reg[15:8];
                ADDR_MASK_LOW:  rdData <= mask_reg[7:0];
                ADDR_EDGE_HIGH: rdData <= edge_reg[15:8];
                ADDR_EDGE_LOW:  rdData <= edge_reg[7:0];
                ADDR_PEND_HIGH: rdData <= pend_reg[15:8];
                ADDR_PEND_LOW:  rdData <= pend_reg[7:0];
                ADDR_STATUS:    rdData <= {7'h00, exitFlag_reg};
                default:        rdData <= 8'h00;
            endcase
        end
    end

    // checks
    property p_srcPin;
        @(posedge sys_clk) disable iff (!rst_b)
        (clkEn && !srcSel_reg) |=> (sharedExtIrqChannel == $past(pin2_reg));
    endproperty
    a_srcPin: assert property (p_srcPin) else $error("channel not from pin");

    property p_edgeSet;
        @(posedge sys_clk) disable iff (!rst_b)
        (clkEn && hit[0]) |=> pend_reg[0];
    endproperty
    a_edgeSet: assert property (p_edgeSet) else $error("pending not set");

    property p_ackAbort;
        @(posedge sys_clk) disable iff (!rst_b)
        (clkEn && cpuAck && pm_reg == PM_RUN) |=> (!stopBit_reg && seq_reg == SEQ_IDLE);
    endproperty
    a_ackAbort: assert property (p_ackAbort) else $error("ack did not abort");

    property p_wakeExit;
        @(posedge sys_clk) disable iff (!rst_b)
        (clkEn && pm_reg == PM_STOP && wakeEvent) |=> (exitFlag_reg && !stopBit_reg);
    endproperty
    a_wakeExit: assert property (p_wakeExit) else $error("bad stop exit");

    property p_entryCond;
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(pm_reg == PM_STOP) |-> $past(seqOk) && $past(seq_reg) == SEQ_ZERO;
    endproperty
    a_entryCond: assert property (p_entryCond) else $error("stop without conditions");

    property p_noStopWake;
        @(posedge sys_clk) disable iff (!rst_b)
        (clkEn && pm_reg == PM_RUN && wakeEvent) |=> pm_reg == PM_RUN;
    endproperty
    a_noStopWake: assert property (p_noStopWake) else $error("stop despite wake");

    property p_chanRise;
        @(posedge sys_clk) disable iff (!rst_b)
        (clkEn && srcSel_reg && anyActive && !$past(anyActive)) |=> sharedExtIrqChannel;
    endproperty
    a_chanRise: assert property (p_chanRise) else $error("no channel edge");

    property p_restart;
        @(posedge sys_clk) disable iff (!rst_b)
        (clkEn && pm_reg == PM_RESTART && oscCnt_reg < 32'(OSC_CYC - 1)) |=> !clockRun;
    endproperty
    a_restart: assert property (p_restart) else $error("clock ran early");

    property p_skipHold;
        @(posedge sys_clk) disable iff (!rst_b)
        (clkEn && pm_reg == PM_RUN && stopWr && skip_reg != 2'h0)
            |=> !stopBit_reg && pm_reg == PM_RUN;
    endproperty
    a_skipHold: assert property (p_skipHold) else $error("broken sequence set stop");

    c_enter:  cover property (@(posedge sys_clk) $rose(stopMode));
    c_exit:   cover property (@(posedge sys_clk) $fell(stopMode));
    c_abort:  cover property (@(posedge sys_clk) seq_reg == SEQ_ZERO && cpuAck);
    c_isrWake: cover property (@(posedge sys_clk) seq_reg == SEQ_ONE && wakeEvent && cpuIrqEnable);
endmodule : wlm_wake_line_manager

//--- sim/wlm_line_partner.sv
// wlm_line_partner: wake pins and cpu interrupt side facing the wake line manager
// assumes the bench sets pin levels, cpu irq enable and dma acknowledges
`timescale 1ns/1ns
module wlm_line_partner (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [15:0] lineLvl,
    input  wire logic        pinLvl,
    input  wire logic        irqOn,
    input  wire logic        ackSlow,
    input  wire logic        dmaAck,
    input  wire logic        sharedExtIrqChannel,
    output logic      [15:0] extraWakeLine,
    output logic             dedicatedExtIrqPin,
    output logic             cpuAck
);
    logic       chanDly;
    logic [3:0] waitCnt;
    // pins driven at all times
    always_ff @(posedge sys_clk)
    begin
        extraWakeLine      <= lineLvl;
        dedicatedExtIrqPin <= pinLvl;
    end
    // cpu acks a channel rising edge after a short or ackSlow delay only while irqOn; dmaAck reaches cpuAck one cycle later whatever irqOn
    always_ff @(posedge sys_clk)
    begin
        chanDly <= sharedExtIrqChannel;
        cpuAck  <= dmaAck || (waitCnt == 4'h1);
        if (!rst_b)
            waitCnt <= 4'h0;
        else if (irqOn && sharedExtIrqChannel && !chanDly)
            waitCnt <= ackSlow ? 4'h7 : 4'h2;
        else if (waitCnt != 4'h0)
            waitCnt <= waitCnt - 4'h1;
    end
endmodule : wlm_line_partner

//--- sim/wlm_wake_line_manager_tb.sv
// wlm_wake_line_manager_tb: self-checking bench for the wake line manager
// assumes the partner model on the pins and a 50 MHz system clock
`timescale 1ns/1ns
module wlm_wake_line_manager_tb;
    import wlm_pkg::*;
    localparam int OSC = 4;
    logic        sys_clk = 1'b0;
    logic        rst_b   = 1'b0;
    logic        clkEn   = 1'b1;
    wlm_bus_s    bus     = '0;
    logic [15:0] lineLvl = 16'h0000;
    logic        pinLvl  = 1'b0;
    logic        irqOn   = 1'b0;
    logic        ackSlow = 1'b0;
    logic        dmaAck  = 1'b0;
    logic        rdSeen  = 1'b0;
    logic [7:0]  rdData;
    logic [15:0] extraWakeLine;
    logic        dedicatedExtIrqPin;
    logic        cpuAck;
    logic        sharedExtIrqChannel;
    logic        stopMode;
    logic        clockRun;
    logic [7:0]  expQ[$];
    string       nameQ[$];
    int          nFail      = 0;
    int          checkCount = 0;
    int          n;
    logic [7:0]  v;

    always #10 sys_clk = ~sys_clk;

    wlm_wake_line_manager #(.OSC_CYC(OSC)) DUT (
        .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .bus(bus), .rdData(rdData),
        .extraWakeLine(extraWakeLine), .dedicatedExtIrqPin(dedicatedExtIrqPin),
        .cpuIrqEnable(irqOn), .cpuAck(cpuAck), .sharedExtIrqChannel(sharedExtIrqChannel),
        .stopMode(stopMode), .clockRun(clockRun));

    wlm_line_partner farSide (
        .sys_clk(sys_clk), .rst_b(rst_b), .lineLvl(lineLvl), .pinLvl(pinLvl), .irqOn(irqOn),
        .ackSlow(ackSlow), .dmaAck(dmaAck), .sharedExtIrqChannel(sharedExtIrqChannel),
        .extraWakeLine(extraWakeLine), .dedicatedExtIrqPin(dedicatedExtIrqPin),
        .cpuAck(cpuAck));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            nFail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrapUp();
        if (nFail == 0 && checkCount > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrapUp

    task automatic cyc(input logic [2:0] a, input logic [7:0] d, input logic w, input logic r);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask : cyc

    task automatic idle(input int k);
        repeat (k) cyc(3'h0, 8'h00, 1'b0, 1'b0);
        #1;
    endtask : idle

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        cyc(a, d, 1'b1, 1'b0);
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string what);
        expQ.push_back(e);
        nameQ.push_back(what);
        cyc(a, 8'h00, 1'b0, 1'b1);
        idle(1);
    endtask : rd

    task automatic waitRun(input int lim, output int cnt);
        cnt = 0;
        while (clockRun !== 1'b1 && cnt < lim)
        begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
        if (cnt >= lim)
        begin
            nFail++;
            wrapUp();
        end
    endtask : waitRun

    // sequence with an optional ack or line pulse after the first write
    task automatic noStop(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
                          input int mode);
        wr(ADDR_CTRL, a);
        dmaAck  <= (mode == 1);
        lineLvl <= (mode == 2) ? 16'h0008 : 16'h0000;
        idle(2);
        dmaAck  <= 1'b0;
        lineLvl <= 16'h0000;
        idle(4);
        wr(ADDR_CTRL, b);
        wr(ADDR_CTRL, c);
        idle(4);
        check("no stop", 8'(stopMode), 8'h00);
        rd(ADDR_CTRL, c & 8'hfb, "stop bit clear");
        rd(ADDR_STATUS, 8'h00, "no exit flag");
    endtask : noStop

    // read results compared when they appear
    always @(posedge sys_clk)
    begin
        if (rdSeen)
            check(nameQ.pop_front(), rdData, expQ.pop_front());
        rdSeen <= bus.rd && clkEn;
    end

    initial
    begin
        #1000000;
        nFail++;
        wrapUp();
    end

    initial
    begin
        n = $urandom(69);
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 8; a++)
            rd(3'(a), 8'h00, "reset value");
        check("clockRun reset", 8'(clockRun), 8'h01);
        for (int a = 1; a < 5; a++)
        begin
            v = 8'($urandom);
            wr(3'(a), v);
            rd(3'(a), v, "mask or edge");
        end
        wr(ADDR_MASK_LOW, 8'h00);
        wr(ADDR_MASK_HIGH, 8'h00);
        wr(ADDR_EDGE_HIGH, 8'hff);
        wr(ADDR_EDGE_LOW, 8'hfe);
        idle(1);
        clkEn <= 1'b0;
        wr(ADDR_MASK_LOW, 8'h5a);
        idle(1);
        clkEn <= 1'b1;
        rd(ADDR_MASK_LOW, 8'h00, "frozen write");
        lineLvl <= 16'h0009;
        idle(8);
        rd(ADDR_PEND_LOW, 8'h08, "rising pend");
        lineLvl <= 16'h0008;
        idle(8);
        rd(ADDR_PEND_LOW, 8'h09, "falling pend");
        wr(ADDR_PEND_LOW, 8'h00);
        rd(ADDR_PEND_LOW, 8'h00, "clear held line");
        pinLvl <= 1'b1;
        idle(6);
        check("pin to channel", 8'(sharedExtIrqChannel), 8'h01);
        wr(ADDR_MASK_LOW, 8'h08);
        wr(ADDR_CTRL, 8'h02);
        lineLvl <= 16'h000a;
        idle(6);
        check("pin cut, line masked", 8'(sharedExtIrqChannel), 8'h00);
        pinLvl  <= 1'b0;
        lineLvl <= 16'h0002;
        idle(4);
        lineLvl <= 16'h000a;
        idle(6);
        check("line to channel", 8'(sharedExtIrqChannel), 8'h01);
        wr(ADDR_CTRL, 8'h00);
        idle(4);
        check("lines cut", 8'(sharedExtIrqChannel), 8'h00);
        wr(ADDR_PEND_LOW, 8'h00);
        lineLvl <= 16'h0000;
        idle(6);
        irqOn <= 1'b0;
        wr(ADDR_CTRL, 8'h05);
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_CTRL, 8'h05);
        idle(3);
        check("stop entered", 8'(stopMode), 8'h01);
        rd(ADDR_CTRL, 8'h05, "stop bit set");
        lineLvl <= 16'h0002;
        idle(10);
        check("masked line no wake", 8'(clockRun), 8'h00);
        lineLvl <= 16'h000a;
        waitRun(40, n);
        check("restart delay", 8'(n >= OSC), 8'h01);
        rd(ADDR_CTRL, 8'h01, "stop bit after exit");
        rd(ADDR_STATUS, 8'h01, "exit flag");
        idle(10);
        rd(ADDR_STATUS, 8'h01, "exit flag sticks");
        rd(ADDR_PEND_LOW, 8'h0a, "wake pend");
        wr(ADDR_PEND_LOW, 8'h00);
        rd(ADDR_PEND_LOW, 8'h00, "clear after exit");
        noStop(8'h05, 8'h01, 8'h05, 1);
        noStop(8'h05, 8'h01, 8'h05, 2);
        rd(ADDR_PEND_LOW, 8'h08, "pend after wake");
        wr(ADDR_PEND_LOW, 8'h00);
        irqOn   <= 1'b1;
        ackSlow <= 1'b1;
        noStop(8'h07, 8'h03, 8'h07, 2);
        rd(ADDR_PEND_LOW, 8'h08, "pend after isr");
        wr(ADDR_PEND_LOW, 8'h00);
        irqOn <= 1'b0;
        noStop(8'h04, 8'h00, 8'h04, 0);
        wr(ADDR_MASK_LOW, 8'h00);
        noStop(8'h05, 8'h01, 8'h05, 0);
        wr(ADDR_MASK_LOW, 8'h08);
        lineLvl <= 16'h0008;
        idle(8);
        noStop(8'h05, 8'h01, 8'h05, 0);
        wr(ADDR_PEND_LOW, 8'h00);
        noStop(8'h05, 8'h05, 8'h01, 0);
        wr(ADDR_CTRL, 8'h01);
        noStop(8'h05, 8'h01, 8'h01, 0);
        idle(4);
        wrapUp();
    end
endmodule : wlm_wake_line_manager_tb
